// File: core/bcs_charge_seq.sv
// Charge sequencer top: trickle, constant current, float, timers, status pin.
// Assumes comparator levels arrive as logic inputs, asynchronous to clk.
`timescale 1ns/1ns

module bcs_charge_seq #(
	parameter int unsigned TICK_CYC = bcs_pkg::TICK_CYC,
	parameter int unsigned TRICKLE_TIMEOUT_S = bcs_pkg::TRICKLE_TIMEOUT_S,
	parameter int unsigned SAFETY_TIMER_S = bcs_pkg::SAFETY_TIMER_S,
	parameter int unsigned RECHARGE_FILT_CYC = bcs_pkg::RECHARGE_FILT_CYC,
	parameter int unsigned NTC_HALF_CYC = bcs_pkg::NTC_HALF_CYC,
	parameter int unsigned BAD_HALF_CYC = bcs_pkg::BAD_HALF_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Battery comparators
	input wire logic battBelowTrickle,
	input wire logic battAtFloat,
	input wire logic battBelowRecharge,
	input wire logic chargeUnderTenth,
	// Input supply comparators
	input wire logic vbusRiseOk,
	input wire logic vbusFallBad,
	input wire logic inputCurrentLimit,
	// Temperature and mode
	input wire logic temperatureFault,
	input wire logic suspendSel,
	// Regulator controls
	output logic switcherEn,
	output logic suspendLdoEn,
	output logic chargeEn,
	output logic chargeFullCurrent,
	output bcs_pkg::bcs_phase_t chargePhase,
	// Open-drain status pin
	input wire logic chargeStatusIn,
	output logic chargeStatusOut,
	output logic chargeStatusOutOe
);

	logic [8:0] rawIn;
	logic [8:0] syncIn;
	logic sBelowTrickle;
	logic sAtFloat;
	logic sBelowRecharge;
	logic sUnderTenth;
	logic sRiseOk;
	logic sFallBad;
	logic sCurLimit;
	logic sTempFault;
	logic sSuspend;

	logic inputOk_r;
	logic inputOkPrev_r;
	logic restart;
	logic [31:0] tickCnt_r;
	logic secTick;
	logic [31:0] phaseSec_r;
	logic [31:0] safetySec_r;
	logic [31:0] rechFilt_r;
	logic rechLong;
	logic doneSeen_r;
	bcs_pkg::bcs_phase_t phase_r;
	bcs_pkg::bcs_phase_t phase_nxt;
	bcs_pkg::bcs_stat_t stat_r;
	logic statusPullLow;

	// ----------------------------------------
	// Phase decoding
	// ----------------------------------------
	// Phases in which the charger may deliver current
	function automatic logic isChargingPhase(input bcs_pkg::bcs_phase_t p);
		return p == bcs_pkg::CHG_TRICKLE || p == bcs_pkg::CHG_CC || p == bcs_pkg::CHG_CV;
	endfunction

	// ----------------------------------------
	// Input synchronisation
	// ----------------------------------------
	always_comb begin
		rawIn = {battBelowTrickle, battAtFloat, battBelowRecharge, chargeUnderTenth,
			vbusRiseOk, vbusFallBad, inputCurrentLimit, temperatureFault, suspendSel};
	end

	bcs_sync #(
		.WIDTH(9)
	) uSync (
		.clk(clk),
		.srst(srst),
		.rawIn(rawIn),
		.syncOut(syncIn)
	);

	always_comb begin
		{sBelowTrickle, sAtFloat, sBelowRecharge, sUnderTenth,
			sRiseOk, sFallBad, sCurLimit, sTempFault, sSuspend} = syncIn;
	end

	// ----------------------------------------
	// Input supply lockout and regulators
	// ----------------------------------------
	// Hysteresis: turning on needs the stricter window, off the looser one
	always_ff @(posedge clk) begin
		if (srst) begin
			inputOk_r <= 1'b0;
		end else if (sFallBad) begin
			inputOk_r <= 1'b0;
		end else if (sRiseOk) begin
			inputOk_r <= 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			inputOkPrev_r <= 1'b0;
		end else begin
			inputOkPrev_r <= inputOk_r;
		end
	end

	// Rising input restarts the whole cycle
	assign restart = inputOk_r & ~inputOkPrev_r;

	// Both enables decode the same terms, so they never overlap
	always_ff @(posedge clk) begin
		if (srst) begin
			switcherEn <= 1'b0;
			suspendLdoEn <= 1'b0;
		end else begin
			switcherEn <= inputOk_r & ~sSuspend;
			suspendLdoEn <= sSuspend & ~(inputOk_r & ~sSuspend);
		end
	end

	// ----------------------------------------
	// One-second time base
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (srst || tickCnt_r == 32'(TICK_CYC - 1)) begin
			tickCnt_r <= '0;
		end else begin
			tickCnt_r <= tickCnt_r + 32'h1;
		end
	end

	assign secTick = (tickCnt_r == 32'(TICK_CYC - 1));

	// ----------------------------------------
	// Recharge dip filter
	// ----------------------------------------
	// Brief dips are ignored; only a continuous dip counts
	always_ff @(posedge clk) begin
		if (srst || !sBelowRecharge) begin
			rechFilt_r <= '0;
		end else if (!rechLong) begin
			rechFilt_r <= rechFilt_r + 32'h1;
		end
	end

	assign rechLong = (rechFilt_r > 32'(RECHARGE_FILT_CYC));

	// ----------------------------------------
	// Phase sequencing
	// ----------------------------------------
	always_comb begin
		phase_nxt = phase_r;
		if (!inputOk_r) begin
			phase_nxt = bcs_pkg::CHG_OFF;
		end else if (restart) begin
			phase_nxt = sBelowTrickle ? bcs_pkg::CHG_TRICKLE : bcs_pkg::CHG_CC;
		end else begin
			unique case (phase_r)
				bcs_pkg::CHG_OFF: phase_nxt = bcs_pkg::CHG_OFF;
				bcs_pkg::CHG_TRICKLE: begin
					if (!sBelowTrickle) begin
						phase_nxt = bcs_pkg::CHG_CC;
					end else if (phaseSec_r >= 32'(TRICKLE_TIMEOUT_S)) begin
						phase_nxt = bcs_pkg::CHG_BADBATT;
					end
				end
				bcs_pkg::CHG_CC: begin
					if (sAtFloat) begin
						phase_nxt = bcs_pkg::CHG_CV;
					end
				end
				bcs_pkg::CHG_CV: begin
					if (safetySec_r >= 32'(SAFETY_TIMER_S)) begin
						phase_nxt = bcs_pkg::CHG_TERM;
					end
				end
				bcs_pkg::CHG_TERM: begin
					if (rechLong) begin
						phase_nxt = sBelowTrickle ? bcs_pkg::CHG_TRICKLE : bcs_pkg::CHG_CC;
					end
				end
				bcs_pkg::CHG_BADBATT: phase_nxt = bcs_pkg::CHG_BADBATT;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			phase_r <= bcs_pkg::CHG_OFF;
		end else begin
			phase_r <= phase_nxt;
		end
	end

	// ----------------------------------------
	// Trickle timeout
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (srst || phase_nxt != phase_r) begin
			phaseSec_r <= '0;
		end else if (secTick && phase_r == bcs_pkg::CHG_TRICKLE) begin
			phaseSec_r <= phaseSec_r + 32'h1;
		end
	end

	// ----------------------------------------
	// Safety timer
	// ----------------------------------------
	// Starts at float entry; frozen while temperature is out of range
	always_ff @(posedge clk) begin
		if (srst || phase_r != bcs_pkg::CHG_CV) begin
			safetySec_r <= '0;
		end else if (rechLong) begin
			safetySec_r <= '0;
		end else if (secTick && !sTempFault) begin
			safetySec_r <= safetySec_r + 32'h1;
		end
	end

	// ----------------------------------------
	// Charge current commands
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (srst) begin
			chargeEn <= 1'b0;
			chargeFullCurrent <= 1'b0;
			chargePhase <= bcs_pkg::CHG_OFF;
		end else begin
			chargePhase <= phase_r;
			chargeEn <= isChargingPhase(phase_r) && !sTempFault;
			chargeFullCurrent <= (phase_r == bcs_pkg::CHG_CC ||
				phase_r == bcs_pkg::CHG_CV);
		end
	end

	// ----------------------------------------
	// End-of-charge detection
	// ----------------------------------------
	// Current limit starves the charger, so low current then means nothing
	always_ff @(posedge clk) begin
		if (srst || phase_r != bcs_pkg::CHG_CV) begin
			doneSeen_r <= 1'b0;
		end else if (sAtFloat && sUnderTenth && !sCurLimit) begin
			doneSeen_r <= 1'b1;
		end
	end

	// ----------------------------------------
	// Status selection
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (srst) begin
			stat_r <= bcs_pkg::STAT_DONE;
		end else if (phase_r == bcs_pkg::CHG_BADBATT) begin
			stat_r <= bcs_pkg::STAT_BAD;
		end else if (sTempFault && isChargingPhase(phase_r)) begin
			stat_r <= bcs_pkg::STAT_NTC;
		end else if (phase_r == bcs_pkg::CHG_OFF || phase_r == bcs_pkg::CHG_TERM ||
			doneSeen_r) begin
			stat_r <= bcs_pkg::STAT_DONE;
		end else begin
			stat_r <= bcs_pkg::STAT_CHARGING;
		end
	end

	bcs_status_pwm #(
		.SLOT_CYC(bcs_pkg::PWM_SLOT_CYC),
		.NTC_HALF(NTC_HALF_CYC),
		.BAD_HALF(BAD_HALF_CYC)
	) uStatus (
		.clk(clk),
		.srst(srst),
		.mode(stat_r),
		.pullLow(statusPullLow)
	);

	// ----------------------------------------
	// Open-drain pin
	// ----------------------------------------
	// Pin level is never driven high; readback is not needed
	always_ff @(posedge clk) begin
		if (srst) begin
			chargeStatusOut <= 1'b0;
		end else begin
			chargeStatusOut <= 1'b0 & chargeStatusIn;
		end
	end

	assign chargeStatusOutOe = statusPullLow;

endmodule

// File: core/bcs_pkg.sv
// Constants, enumerations and timing figures for the charge sequencer.
// Assumes a single 125 MHz clock; all long counts are derived here.

package bcs_pkg;

	// ----------------------------------------
	// Clock and time base
	// ----------------------------------------
	localparam int unsigned CLK_HZ = 125_000_000;
	localparam int unsigned TICK_CYC = CLK_HZ;
	localparam int unsigned TRICKLE_TIMEOUT_S = 1800;
	localparam int unsigned SAFETY_TIMER_S = 14400;
	localparam longint unsigned RECHARGE_FILT_NS = 1_300_000;
	localparam int unsigned RECHARGE_FILT_CYC =
		int'((RECHARGE_FILT_NS * CLK_HZ + 999_999_999) / 1_000_000_000);

	// ----------------------------------------
	// Status pin modulation
	// ----------------------------------------
	localparam int unsigned STATUS_PWM_HZ = 35_000;
	localparam int unsigned PWM_SLOTS = 16;
	localparam int unsigned PWM_SLOT_CYC = CLK_HZ / (STATUS_PWM_HZ * PWM_SLOTS);
	localparam logic [3:0] NTC_DUTY_LO = 4'h1;
	localparam logic [3:0] NTC_DUTY_HI = 4'hF;
	localparam logic [3:0] BAD_DUTY_LO = 4'h2;
	localparam logic [3:0] BAD_DUTY_HI = 4'hE;
	localparam longint unsigned NTC_BLINK_MILLIHZ = 1500;
	localparam longint unsigned BAD_BLINK_MILLIHZ = 6100;
	localparam int unsigned NTC_HALF_CYC =
		int'((64'(CLK_HZ) * 1000) / (2 * NTC_BLINK_MILLIHZ));
	localparam int unsigned BAD_HALF_CYC =
		int'((64'(CLK_HZ) * 1000) / (2 * BAD_BLINK_MILLIHZ));

	// ----------------------------------------
	// Enumerations
	// ----------------------------------------
	typedef enum logic [2:0] {
		CHG_OFF,
		CHG_TRICKLE,
		CHG_CC,
		CHG_CV,
		CHG_TERM,
		CHG_BADBATT
	} bcs_phase_t;

	typedef enum logic [1:0] {
		STAT_CHARGING,
		STAT_DONE,
		STAT_NTC,
		STAT_BAD
	} bcs_stat_t;

endpackage

// File: core/bcs_sync.sv
// Two-flop synchroniser for a vector of comparator levels.
// Assumes levels change slowly compared with the clock.
`timescale 1ns/1ns

module bcs_sync #(
	parameter int WIDTH = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Levels
	input wire logic [WIDTH-1:0] rawIn,
	output logic [WIDTH-1:0] syncOut
);

	logic [WIDTH-1:0] stage1_r;

	// First stage feeds only the second
	always_ff @(posedge clk) begin
		if (srst) begin
			stage1_r <= '0;
			syncOut <= '0;
		end else begin
			stage1_r <= rawIn;
			syncOut <= stage1_r;
		end
	end

endmodule

// File: core/bcs_status_pwm.sv
// Status pin encoder: steady low, released, or 35 kHz blinking patterns.
// Assumes the mode input is registered by the caller.
`timescale 1ns/1ns

module bcs_status_pwm #(
	parameter int unsigned SLOT_CYC = bcs_pkg::PWM_SLOT_CYC,
	parameter int unsigned NTC_HALF = bcs_pkg::NTC_HALF_CYC,
	parameter int unsigned BAD_HALF = bcs_pkg::BAD_HALF_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Mode
	input wire bcs_pkg::bcs_stat_t mode,
	// Pin drive, high pulls the pin low
	output logic pullLow
);

	logic [15:0] slotCnt_r;
	logic [3:0] slotIdx_r;
	logic [31:0] blinkCnt_r;
	logic blinkHi_r;
	logic [31:0] halfCyc;
	logic [3:0] duty;

	// ----------------------------------------
	// 35 kHz carrier, sixteen slots a period
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (srst) begin
			slotCnt_r <= '0;
			slotIdx_r <= '0;
		end else if (slotCnt_r == 16'(SLOT_CYC - 1)) begin
			slotCnt_r <= '0;
			slotIdx_r <= slotIdx_r + 4'h1;
		end else begin
			slotCnt_r <= slotCnt_r + 16'h0001;
		end
	end

	// ----------------------------------------
	// Blink phase, half period each
	// ----------------------------------------
	always_comb begin
		halfCyc = (mode == bcs_pkg::STAT_BAD) ? 32'(BAD_HALF) : 32'(NTC_HALF);
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			blinkCnt_r <= '0;
			blinkHi_r <= 1'b0;
		end else if (blinkCnt_r >= halfCyc - 32'h1) begin
			blinkCnt_r <= '0;
			blinkHi_r <= ~blinkHi_r;
		end else begin
			blinkCnt_r <= blinkCnt_r + 32'h1;
		end
	end

	always_comb begin
		if (mode == bcs_pkg::STAT_BAD) begin
			duty = blinkHi_r ? bcs_pkg::BAD_DUTY_HI : bcs_pkg::BAD_DUTY_LO;
		end else begin
			duty = blinkHi_r ? bcs_pkg::NTC_DUTY_HI : bcs_pkg::NTC_DUTY_LO;
		end
	end

	// ----------------------------------------
	// Pin drive
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (srst) begin
			pullLow <= 1'b0;
		end else begin
			unique case (mode)
				bcs_pkg::STAT_CHARGING: pullLow <= 1'b1;
				bcs_pkg::STAT_DONE: pullLow <= 1'b0;
				bcs_pkg::STAT_NTC,
				bcs_pkg::STAT_BAD: pullLow <= (slotIdx_r < duty);
			endcase
		end
	end

endmodule

// File: testbench/bcs_charge_seq_asserts.sv
// Checker for the charge sequencer top ports.
// Assumes one clock domain; bound to every bcs_charge_seq instance.
`timescale 1ns/1ns

module bcs_charge_seq_asserts (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Inputs watched
	input wire logic vbusFallBad,
	input wire logic temperatureFault,
	input wire logic suspendSel,
	// Outputs watched
	input wire logic switcherEn,
	input wire logic suspendLdoEn,
	input wire logic chargeEn,
	input wire logic chargeFullCurrent,
	input wire bcs_pkg::bcs_phase_t chargePhase,
	input wire logic chargeStatusOut,
	input wire logic chargeStatusOutOe
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	// ----
	// Steady phases, three cycles (eight for sCcCool) so a phase edge never trips them
	// ----
	sequence sTrickle; (chargePhase == bcs_pkg::CHG_TRICKLE)[*3]; endsequence
	sequence sCc; (chargePhase == bcs_pkg::CHG_CC)[*3]; endsequence
	sequence sCcCool; (chargePhase == bcs_pkg::CHG_CC && !temperatureFault)[*8]; endsequence
	AST_TRICKLE_TENTH: assert property (sTrickle |-> !chargeFullCurrent)
		else $error("Full current while trickling");
	AST_CC_FULL: assert property (sCc and chargeEn[*3] |-> chargeFullCurrent)
		else $error("Reduced current in constant current");
	AST_BAD_STOP: assert property ((chargePhase == bcs_pkg::CHG_BADBATT)[*3] |-> !chargeEn)
		else $error("Charging with bad battery");
	AST_TERM_STOP: assert property ((chargePhase == bcs_pkg::CHG_TERM)[*3] |-> !chargeEn)
		else $error("Charging after termination");
	AST_CHG_LOW: assert property (sCcCool |-> chargeStatusOutOe && !chargeStatusOut)
		else $error("Status not low while charging");
	AST_FALL_OFF: assert property (vbusFallBad[*6] |-> !switcherEn)
		else $error("Switcher on with input low");
	AST_SUSP_OFF: assert property (suspendSel[*6] |-> !switcherEn)
		else $error("Switcher on in suspend");
	AST_LDO_EXCL: assert property (suspendLdoEn |-> !switcherEn)
		else $error("Suspend regulator with switcher on");
	AST_TEMP_PAUSE: assert property (temperatureFault[*8] |-> !chargeEn)
		else $error("Charging with temperature fault");
endmodule

bind bcs_charge_seq bcs_charge_seq_asserts chk_u (
	.clk(clk),
	.srst(srst),
	.vbusFallBad(vbusFallBad),
	.temperatureFault(temperatureFault),
	.suspendSel(suspendSel),
	.switcherEn(switcherEn),
	.suspendLdoEn(suspendLdoEn),
	.chargeEn(chargeEn),
	.chargeFullCurrent(chargeFullCurrent),
	.chargePhase(chargePhase),
	.chargeStatusOut(chargeStatusOut),
	.chargeStatusOutOe(chargeStatusOutOe)
);

// File: testbench/bcs_batt_model.sv
// Cell and status pull-up: comparator levels from a millivolt figure.
// Assumes the bench loads the voltage; cell only rises at full current.
`timescale 1ns/1ns

module bcs_batt_model (
	// Clock
	input wire logic clk,
	// Charger side
	input wire logic chargeEn,
	input wire logic chargeFullCurrent,
	input wire logic statusOe,
	// Bench control
	input wire logic loadEn,
	input wire logic [15:0] loadMv,
	// Comparator levels and pin
	output logic battBelowTrickle,
	output logic battAtFloat,
	output logic battBelowRecharge,
	output logic chargeUnderTenth,
	output logic statusPin
);
	int mv = 3700;
	// Dead cell in trickle, so the trickle timeout can be reached
	always @(posedge clk) begin
		if (loadEn) mv <= int'(loadMv);
		else if (chargeEn && chargeFullCurrent && mv < 4200) mv <= mv + 2;
	end
	assign battBelowTrickle = mv < 2850;
	assign battAtFloat = mv >= 4200;
	assign battBelowRecharge = mv < 4100;
	// Current tapers once at float
	assign chargeUnderTenth = battAtFloat;
	// Pull-up on the open-drain line
	assign statusPin = statusOe ? 1'b0 : 1'b1;
endmodule

// File: testbench/tb_top.sv
// Self-checking bench for the charge sequencer with shortened timers.
// Assumes the cell model supplies all battery comparator levels.
`timescale 1ns/1ns

module tb_top;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic vbusRiseOk = 1'b0;
	logic vbusFallBad = 1'b0;
	logic inputCurrentLimit = 1'b0;
	logic temperatureFault = 1'b0;
	logic suspendSel = 1'b0;
	logic loadEn = 1'b0;
	logic [15:0] loadMv = 16'h0E74;
	logic bBt, bAf, bBr, cUt, statusPin;
	logic switcherEn, suspendLdoEn, chargeEn, chargeFullCurrent, statusOut, statusOe;
	bcs_pkg::bcs_phase_t chargePhase;
	int mismatches = 0;
	int n_compared = 0;
	int cyc = 0;
	int n;
	int k;
	int nLo;
	int nHi;
	int nOdd;
	// Low-run lengths of the status pin, from the slot width and duty figures
	localparam int slotCyc = int'(bcs_pkg::PWM_SLOT_CYC);
	localparam int badLoRun = int'(bcs_pkg::BAD_DUTY_LO) * slotCyc;
	localparam int badHiRun = int'(bcs_pkg::BAD_DUTY_HI) * slotCyc;
	localparam int ntcLoRun = int'(bcs_pkg::NTC_DUTY_LO) * slotCyc;
	localparam int ntcHiRun = int'(bcs_pkg::NTC_DUTY_HI) * slotCyc;
	always #4 clk = ~clk;

	// Temperature blink stays at its real rate; only its duty is checked
	// Bad-battery half period spans over two carrier periods, so full runs show
	bcs_charge_seq #(.TICK_CYC(10), .TRICKLE_TIMEOUT_S(5), .SAFETY_TIMER_S(8),
		.RECHARGE_FILT_CYC(20), .BAD_HALF_CYC(8000)) dut_u (
		.clk(clk), .srst(srst), .battBelowTrickle(bBt), .battAtFloat(bAf),
		.battBelowRecharge(bBr), .chargeUnderTenth(cUt), .vbusRiseOk(vbusRiseOk),
		.vbusFallBad(vbusFallBad), .inputCurrentLimit(inputCurrentLimit),
		.temperatureFault(temperatureFault), .suspendSel(suspendSel),
		.switcherEn(switcherEn), .suspendLdoEn(suspendLdoEn), .chargeEn(chargeEn),
		.chargeFullCurrent(chargeFullCurrent), .chargePhase(chargePhase),
		.chargeStatusIn(statusPin), .chargeStatusOut(statusOut),
		.chargeStatusOutOe(statusOe));
	bcs_batt_model cell_u (.clk(clk), .chargeEn(chargeEn),
		.chargeFullCurrent(chargeFullCurrent), .statusOe(statusOe), .loadEn(loadEn),
		.loadMv(loadMv), .battBelowTrickle(bBt), .battAtFloat(bAf),
		.battBelowRecharge(bBr), .chargeUnderTenth(cUt), .statusPin(statusPin));

	// ----
	// Helpers
	// ----
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic waitPhase(input bcs_pkg::bcs_phase_t p, input int lim, output int cnt);
		cnt = 0;
		while (chargePhase !== p && cnt < lim) begin
			@(negedge clk);
			cnt++;
		end
		chk(16'(chargePhase), 16'(p));
	endtask
	task automatic load(input logic [15:0] v);
		loadMv = v;
		loadEn = 1'b1;
		@(negedge clk);
		loadEn = 1'b0;
	endtask
	task automatic step(input int c);
		repeat (c) @(negedge clk);
	endtask
	// Host side of the status pin: times every low run as a microprocessor would
	task automatic hostDecode(input int cycles, output int lo, output int hi, output int odd);
		int run;
		run = 0;
		lo = 0;
		hi = 0;
		odd = 0;
		repeat (cycles) begin
			@(negedge clk);
			if (statusPin === 1'b0) begin
				run++;
			end else if (run > 0) begin
				if (run == badLoRun) lo++;
				else if (run == badHiRun) hi++;
				else if (run != 8 * slotCyc) odd++;
				run = 0;
			end
		end
	endtask
	task automatic end_sim;
		$display("Compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask

	// Ceiling well above the roughly 30000 cycles of the sequence
	always @(posedge clk) begin
		cyc++;
		if (cyc == 40000) begin
			mismatches++;
			end_sim;
		end
	end

	// ----
	// Sequence
	// ----
	initial begin
		k = $urandom(52475);
		step(5);
		srst = 1'b0;
		step(1);
		chk({switcherEn, chargeEn, statusOe, 3'(chargePhase)}, 16'h0000);
		$display("Test reset done");
		load(16'h07D0 + 16'($urandom % 16'h0320));
		vbusRiseOk = 1'b1;
		waitPhase(bcs_pkg::CHG_TRICKLE, 20, n);
		step(3);
		chk({switcherEn, chargeEn, chargeFullCurrent, statusPin}, 16'h000C);
		waitPhase(bcs_pkg::CHG_BADBATT, 100, n);
		step(8);
		// Three half periods: both duties show whole runs; cut runs only at the window start and blink edges
		hostDecode(24000, nLo, nHi, nOdd);
		chk(16'(nLo > 0 && nHi > 0 && nOdd <= 3), 16'h0001);
		chk({chargeEn, 3'(chargePhase)}, 16'(bcs_pkg::CHG_BADBATT));
		$display("Test bad battery done");
		inputCurrentLimit = 1'b1;
		vbusFallBad = 1'b1;
		load(16'h0BB8 + 16'($urandom % 16'h03E8));
		step(10);
		vbusFallBad = 1'b0;
		waitPhase(bcs_pkg::CHG_CC, 40, n);
		step(3);
		chk({chargeFullCurrent, statusPin}, 16'h0002);
		waitPhase(bcs_pkg::CHG_CV, 700, n);
		step(20);
		chk(16'(statusPin), 16'h0000);
		inputCurrentLimit = 1'b0;
		step(20);
		chk(16'(statusPin), 16'h0001);
		waitPhase(bcs_pkg::CHG_TERM, 100, n);
		chk(16'(n + 41 >= 65 && n + 41 <= 100), 16'h0001);
		chk(16'(chargeEn), 16'h0000);
		$display("Test charge cycle done");
		load(16'h0FD2);
		step(1 + $urandom % 12);
		load(16'h1068);
		step(40);
		chk(16'(chargePhase), 16'(bcs_pkg::CHG_TERM));
		load(16'h0FD2);
		waitPhase(bcs_pkg::CHG_CC, 60, n);
		waitPhase(bcs_pkg::CHG_CV, 200, n);
		$display("Test recharge done");
		temperatureFault = 1'b1;
		step(10);
		chk(16'(chargeEn), 16'h0000);
		step(100);
		chk(16'(chargePhase), 16'(bcs_pkg::CHG_CV));
		// One carrier period: blink phase cannot change at the real rate
		k = 0;
		repeat (16 * slotCyc) begin
			@(negedge clk);
			k += int'(statusOe);
		end
		chk(16'(k == ntcLoRun || k == ntcHiRun), 16'h0001);
		chk(16'(chargePhase), 16'(bcs_pkg::CHG_CV));
		temperatureFault = 1'b0;
		waitPhase(bcs_pkg::CHG_TERM, 110, n);
		$display("Test temperature pause done");
		suspendSel = 1'b1;
		step(8);
		chk({switcherEn, suspendLdoEn}, 16'h0001);
		suspendSel = 1'b0;
		step(8);
		chk({switcherEn, suspendLdoEn}, 16'h0002);
		vbusFallBad = 1'b1;
		step(8);
		chk(16'(switcherEn), 16'h0000);
		$display("Test supply done");
		end_sim;
	end
endmodule
